// ===== inc/amb_pkg.sv
package amb_pkg;

  // Core clock and the leaky-bucket evaluation period
  localparam int CLK_HZ = 40_000_000;
  localparam int BUCKET_CYCLE_MS = 128;
  localparam int BUCKET_CYCLE_TICKS = CLK_HZ / 1000 * BUCKET_CYCLE_MS;
  localparam int TICK_W = 23;

  // Register offsets
  localparam logic [7:0] ADDR_UPPER = 8'h5c;
  localparam logic [7:0] ADDR_LOWER = 8'h5d;
  localparam logic [7:0] ADDR_CEILING = 8'h5e;
  localparam logic [7:0] ADDR_LEAK = 8'h5f;
  localparam logic [7:0] ADDR_OUT_EN = 8'h63;
  localparam logic [7:0] ADDR_PATH = 8'h64;
  localparam logic [7:0] ADDR_MEAS = 8'h65;
  localparam logic [7:0] ADDR_ACC = 8'h68;
  localparam logic [7:0] ADDR_STATUS = 8'h69;

  // Reset values
  localparam logic [7:0] RST_UPPER = 8'h06;
  localparam logic [7:0] RST_LOWER = 8'h04;
  localparam logic [7:0] RST_CEILING = 8'h08;
  localparam logic [1:0] RST_LEAK = 2'h1;
  localparam logic [7:0] RST_OUT_EN = 8'hf6;
  localparam logic [7:0] RST_PATH = 8'h01;
  localparam logic [7:0] RST_MEAS = 8'h01;

  // Field positions and writable masks
  localparam int OE_FIRST_BIT = 5;
  localparam int OE_COMP_BIT = 4;
  localparam int PC_SQUELCH_BIT = 6;
  localparam int PC_DUTY_BIT = 5;
  localparam int PC_STD_BIT = 4;
  localparam int PM_MODE_BIT = 7;
  localparam logic [7:0] PATH_MASK = 8'h77;
  localparam logic [7:0] MEAS_MASK = 8'h87;
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_FAIL_BIT = 1;
  localparam int ST_SONET_BIT = 2;
  localparam int ST_FIRST_BIT = 3;
  localparam int ST_COMP_BIT = 4;
  localparam int ST_RUN_BIT = 5;

  // System clock codes of the secondary DPLL
  typedef enum logic [2:0] {
    DPLL_CLK_OFF = 3'h0,
    DPLL_CLK_ON = 3'h1
  } amb_dpll_code_t;

  // Output synthesis
  localparam int NCO_W = 32;
  localparam int FIRST_SDH_HZ = 2_048_000;
  localparam int FIRST_SONET_HZ = 1_544_000;
  localparam int COMP_HZ = 64_000;
  localparam logic [NCO_W-1:0] INC_SDH = NCO_W'((64'(FIRST_SDH_HZ) << NCO_W) / 64'(CLK_HZ));
  localparam logic [NCO_W-1:0] INC_SONET = NCO_W'((64'(FIRST_SONET_HZ) << NCO_W) / 64'(CLK_HZ));
  localparam logic [NCO_W-1:0] INC_COMP = NCO_W'((64'(COMP_HZ) << NCO_W) / 64'(CLK_HZ));
  localparam logic [2:0] DUTY58_LIMIT = 3'h5;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amb_reg_req_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
    logic [7:0] ceiling;
    logic [1:0] leak;
  } amb_bucket_cfg_t;

endpackage

// ===== logic/amb_strap_capture.sv
`timescale 1ns/10ps
module amb_strap_capture
  import amb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Strap pin
  input wire logic strapPin,
  // Captured level
  output logic strapLevel,
  output logic strapLoad
);

  logic syncA_r;
  logic syncB_r;
  logic [1:0] settle_r;

  // Strap is caught after release, once the synchroniser holds a real sample
  always_ff @(posedge core_clk) begin
    syncA_r <= strapPin;
    syncB_r <= syncA_r;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      settle_r <= 2'h0;
    end else if (settle_r != 2'h3) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strapLevel <= 1'b0;
      strapLoad <= 1'b0;
    end else begin
      strapLoad <= (settle_r == STRAP_SETTLE);
      if (settle_r == STRAP_SETTLE) begin
        strapLevel <= syncB_r;
      end
    end
  end

endmodule

// ===== logic/amb_clock_gen.sv
`timescale 1ns/10ps
module amb_clock_gen
  import amb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic sonet,
  input wire logic duty58,
  // Synthesised clocks
  output logic firstClk,
  output logic compClk
);

  logic [NCO_W-1:0] firstPhase_r;
  logic [NCO_W-1:0] compPhase_r;

  // Phase accumulators: edges jitter by one core period, the price of one clock
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      firstPhase_r <= '0;
      compPhase_r <= '0;
    end else begin
      firstPhase_r <= firstPhase_r + (sonet ? INC_SONET : INC_SDH);
      compPhase_r <= compPhase_r + INC_COMP;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      firstClk <= 1'b0;
      compClk <= 1'b0;
    end else begin
      firstClk <= firstPhase_r[NCO_W-1];
      if (duty58) begin
        compClk <= (compPhase_r[NCO_W-1 -: 3] < DUTY58_LIMIT);
      end else begin
        compClk <= !compPhase_r[NCO_W-1];
      end
    end
  end

endmodule

// ===== logic/amb_activity_bits_cfg.sv
`timescale 1ns/10ps
module amb_activity_bits_cfg
  import amb_pkg::*;
#(
  parameter int CYCLE_TICKS = BUCKET_CYCLE_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire amb_reg_req_t regReq,
  output logic [7:0] regRdata,
  output logic regRdValid,
  // Activity monitor and path status
  input wire logic inputFailSeen,
  input wire logic secondaryInputsFailed,
  output logic inactivityAlarm,
  // Standard selection from the main device and strap
  input wire logic mainStdOverride,
  input wire logic mainStdSonet,
  input wire logic standardStrapPin,
  // Timing outputs
  output logic firstTimingOutput,
  output logic firstOutputOn,
  output logic compositeTimingOutput,
  output logic secondOutputOn,
  // Secondary DPLL control
  output logic dpllClockRun,
  output logic dpllEnable,
  output logic phaseMeasureMode
);

  amb_bucket_cfg_t bucketCfg_r;
  logic [7:0] outEnables_r;
  logic [7:0] pathCtrl_r;
  logic [7:0] measCtrl_r;

  logic [TICK_W-1:0] tick_r;
  logic cycleEnd;
  logic failSeen_r;
  logic cycleFailed;
  logic [2:0] quiet_r;
  logic [2:0] quiet_nxt;
  logic leakNow;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic alarm_r;

  logic strapLevel;
  logic strapLoad;
  logic stdSonet;
  logic squelchNow;
  logic firstOn;
  logic compOn;
  logic clkRun;
  logic genRun;
  logic firstClk;
  logic compClk;

  // Quiet cycles needed per leak step, less one
  function automatic logic [2:0] leakLast(input logic [1:0] code);
    unique case (code)
      2'h0: leakLast = 3'h0;
      2'h1: leakLast = 3'h1;
      2'h2: leakLast = 3'h3;
      2'h3: leakLast = 3'h7;
    endcase
  endfunction

  function automatic logic hit(input amb_reg_req_t req, input logic [7:0] addr);
    hit = (req.addr == addr);
  endfunction

  // Configuration writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bucketCfg_r.upper <= RST_UPPER;
      bucketCfg_r.lower <= RST_LOWER;
      bucketCfg_r.ceiling <= RST_CEILING;
      bucketCfg_r.leak <= RST_LEAK;
    end else if (regReq.wr) begin
      if (hit(regReq, ADDR_UPPER)) begin
        bucketCfg_r.upper <= regReq.wdata;
      end
      if (hit(regReq, ADDR_LOWER)) begin
        bucketCfg_r.lower <= regReq.wdata;
      end
      if (hit(regReq, ADDR_CEILING)) begin
        bucketCfg_r.ceiling <= regReq.wdata;
      end
      if (hit(regReq, ADDR_LEAK)) begin
        bucketCfg_r.leak <= regReq.wdata[1:0];
      end
    end
  end

  // Unused enable bits are stored so software can read back its power setting
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      outEnables_r <= RST_OUT_EN;
    end else if (regReq.wr && hit(regReq, ADDR_OUT_EN)) begin
      outEnables_r <= regReq.wdata;
    end
  end

  // The strap level lands in the standard bit once; a software write in that same cycle wins over it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pathCtrl_r <= RST_PATH;
    end else if (regReq.wr && hit(regReq, ADDR_PATH)) begin
      pathCtrl_r <= regReq.wdata & PATH_MASK;
    end else if (strapLoad) begin
      pathCtrl_r[PC_STD_BIT] <= strapLevel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      measCtrl_r <= RST_MEAS;
    end else if (regReq.wr && hit(regReq, ADDR_MEAS)) begin
      measCtrl_r <= regReq.wdata & MEAS_MASK;
    end
  end

  // Read port, one cycle latency, unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regReq.rd;
      if (regReq.rd) begin
        unique case (regReq.addr)
          ADDR_UPPER: regRdata <= bucketCfg_r.upper;
          ADDR_LOWER: regRdata <= bucketCfg_r.lower;
          ADDR_CEILING: regRdata <= bucketCfg_r.ceiling;
          ADDR_LEAK: regRdata <= {6'h00, bucketCfg_r.leak};
          ADDR_OUT_EN: regRdata <= outEnables_r;
          ADDR_PATH: regRdata <= pathCtrl_r;
          ADDR_MEAS: regRdata <= measCtrl_r;
          ADDR_ACC: regRdata <= acc_r;
          ADDR_STATUS: begin
            regRdata <= 8'h00;
            regRdata[ST_ALARM_BIT] <= alarm_r;
            regRdata[ST_FAIL_BIT] <= failSeen_r;
            regRdata[ST_SONET_BIT] <= stdSonet;
            regRdata[ST_FIRST_BIT] <= firstOn;
            regRdata[ST_COMP_BIT] <= compOn;
            regRdata[ST_RUN_BIT] <= clkRun;
          end
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end

  // Evaluation cycle timer
  always_ff @(posedge core_clk) begin
    if (sys_rst || cycleEnd) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + TICK_W'(1);
    end
  end

  assign cycleEnd = (tick_r == TICK_W'(CYCLE_TICKS - 1));

  // A failure seen in the closing cycle still counts for that cycle
  assign cycleFailed = failSeen_r || inputFailSeen;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      failSeen_r <= 1'b0;
    end else if (cycleEnd) begin
      failSeen_r <= 1'b0;
    end else if (inputFailSeen) begin
      failSeen_r <= 1'b1;
    end
  end

  // Quiet cycle counting for the leak
  always_comb begin
    quiet_nxt = quiet_r;
    leakNow = 1'b0;
    if (cycleEnd) begin
      if (cycleFailed) begin
        quiet_nxt = 3'h0;
      end else if (quiet_r >= leakLast(bucketCfg_r.leak)) begin
        quiet_nxt = 3'h0;
        leakNow = 1'b1;
      end else begin
        quiet_nxt = quiet_r + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      quiet_r <= 3'h0;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end

  // Accumulator; a lowered ceiling pulls a fuller bucket down on its next fill
  always_comb begin
    acc_nxt = acc_r;
    if (cycleEnd && cycleFailed) begin
      if (acc_r >= bucketCfg_r.ceiling) begin
        acc_nxt = bucketCfg_r.ceiling;
      end else begin
        acc_nxt = acc_r + 8'h01;
      end
    end else if (leakNow && acc_r != 8'h00) begin
      acc_nxt = acc_r - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Alarm hysteresis between the two limits
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alarm_r <= 1'b0;
    end else if (!alarm_r && acc_r >= bucketCfg_r.upper) begin
      alarm_r <= 1'b1;
    end else if (alarm_r && acc_r <= bucketCfg_r.lower) begin
      alarm_r <= 1'b0;
    end
  end

  assign inactivityAlarm = alarm_r;

  // Output gating
  assign stdSonet = mainStdOverride ? mainStdSonet : pathCtrl_r[PC_STD_BIT];
  assign squelchNow = pathCtrl_r[PC_SQUELCH_BIT] && secondaryInputsFailed;
  assign firstOn = outEnables_r[OE_FIRST_BIT] && !squelchNow;
  assign compOn = outEnables_r[OE_COMP_BIT] && !squelchNow;
  // Illegal codes are treated as off so a bad write cannot run a wild clock
  assign clkRun = (amb_dpll_code_t'(pathCtrl_r[2:0]) == DPLL_CLK_ON);
  assign genRun = clkRun && !measCtrl_r[PM_MODE_BIT];

  amb_strap_capture u_strap (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .strapPin(standardStrapPin),
    .strapLevel(strapLevel),
    .strapLoad(strapLoad)
  );

  amb_clock_gen u_clkgen (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(genRun),
    .sonet(stdSonet),
    .duty58(pathCtrl_r[PC_DUTY_BIT]),
    .firstClk(firstClk),
    .compClk(compClk)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      firstTimingOutput <= 1'b0;
      compositeTimingOutput <= 1'b0;
      firstOutputOn <= 1'b0;
      secondOutputOn <= 1'b0;
      dpllClockRun <= 1'b0;
      dpllEnable <= 1'b0;
      phaseMeasureMode <= 1'b0;
    end else begin
      firstTimingOutput <= firstOn && firstClk;
      compositeTimingOutput <= compOn && compClk;
      firstOutputOn <= firstOn;
      secondOutputOn <= compOn;
      dpllClockRun <= clkRun;
      dpllEnable <= genRun;
      phaseMeasureMode <= measCtrl_r[PM_MODE_BIT];
    end
  end

endmodule

// ===== sim/amb_sva.sv
`timescale 1ns/10ps
module amb_sva
  import amb_pkg::*;
#(
  parameter int CYCLE_TICKS = BUCKET_CYCLE_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire amb_reg_req_t regReq,
  input wire logic regRdValid,
  // Squelch source
  input wire logic secondaryInputsFailed,
  // Timing outputs
  input wire logic firstTimingOutput,
  input wire logic firstOutputOn,
  input wire logic compositeTimingOutput,
  input wire logic secondOutputOn,
  // DPLL control
  input wire logic dpllClockRun,
  input wire logic dpllEnable,
  input wire logic phaseMeasureMode
);
  logic oeFirst_r, oeComp_r, squelch_r, run_r, meas_r;
  wire wrPath = regReq.wr && regReq.addr == ADDR_PATH;
  wire wrMeas = regReq.wr && regReq.addr == ADDR_MEAS;
  // Shadows of the enable bits, since the checker sees only the ports
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oeFirst_r <= RST_OUT_EN[OE_FIRST_BIT];
      oeComp_r <= RST_OUT_EN[OE_COMP_BIT];
    end else if (regReq.wr && regReq.addr == ADDR_OUT_EN) begin
      oeFirst_r <= regReq.wdata[OE_FIRST_BIT];
      oeComp_r <= regReq.wdata[OE_COMP_BIT];
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      squelch_r <= RST_PATH[PC_SQUELCH_BIT];
      run_r <= RST_PATH[2:0] == 3'h1;
      meas_r <= RST_MEAS[PM_MODE_BIT];
    end else begin
      if (wrPath) begin
        squelch_r <= regReq.wdata[PC_SQUELCH_BIT];
        run_r <= regReq.wdata[2:0] == 3'h1;
      end
      if (wrMeas) meas_r <= regReq.wdata[PM_MODE_BIT];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (regReq.rd |=> regRdValid)
    else $error("read not answered");
  rd_pulse_a: assert property (regRdValid |-> $past(regReq.rd))
    else $error("read valid without read");
  first_on_a: assert property (!$past(sys_rst) |->
    firstOutputOn == $past(oeFirst_r && !(squelch_r && secondaryInputsFailed)))
    else $error("first output enable wrong");
  comp_on_a: assert property (!$past(sys_rst) |->
    secondOutputOn == $past(oeComp_r && !(squelch_r && secondaryInputsFailed)))
    else $error("composite output enable wrong");
  run_code_a: assert property (wrPath |=> ##[0:1] dpllClockRun == run_r)
    else $error("clock code not applied");
  meas_mode_a: assert property (wrMeas |=> ##[0:1] phaseMeasureMode == meas_r)
    else $error("measure mode not applied");
  dpll_gate_a: assert property (dpllEnable |-> dpllClockRun && !phaseMeasureMode)
    else $error("dpll enabled wrongly");
  first_quiet_a: assert property (!firstOutputOn && !$past(firstOutputOn) |->
    !firstTimingOutput) else $error("first output toggles while off");
  comp_quiet_a: assert property (!secondOutputOn && !$past(secondOutputOn) |->
    !compositeTimingOutput) else $error("composite output toggles while off");
endmodule

// ===== sim/amb_far_end.sv
`timescale 1ns/10ps
module amb_far_end (
  // Clock
  input wire logic core_clk,
  // Bench commands
  input wire logic failCmd,
  input wire logic lossCmd,
  input wire logic ovrCmd,
  input wire logic sonetCmd,
  input wire logic clrCnt,
  input wire logic strapCmd,
  // Reference side
  output logic inputFailSeen = 1'b0,
  output logic secondaryInputsFailed = 1'b0,
  output logic mainStdOverride = 1'b0,
  output logic mainStdSonet = 1'b0,
  output logic standardStrapPin,
  // Clock loads
  input wire logic firstTimingOutput,
  input wire logic compositeTimingOutput,
  output int firstEdges,
  output int compHigh
);
  logic firstPrev_r = 1'b0;
  // Strap level is set by the bench; the design only reads it after a reset
  assign standardStrapPin = strapCmd;
  always_ff @(posedge core_clk) begin
    inputFailSeen <= failCmd;
    secondaryInputsFailed <= lossCmd;
    mainStdOverride <= ovrCmd;
    mainStdSonet <= sonetCmd;
  end
  // Load counts rising edges and high cycles, as a frequency meter would
  always_ff @(posedge core_clk) begin
    firstPrev_r <= firstTimingOutput;
    if (clrCnt) begin
      firstEdges <= 0;
      compHigh <= 0;
    end else begin
      firstEdges <= firstEdges + int'(firstTimingOutput && !firstPrev_r);
      compHigh <= compHigh + int'(compositeTimingOutput);
    end
  end
endmodule

// ===== sim/tb_amb_activity_bits_cfg.sv
`timescale 1ns/10ps
module tb_amb_activity_bits_cfg;
  import amb_pkg::*;
  localparam int LIMIT = 40000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  amb_reg_req_t regReq = '0;
  logic failCmd = 0, lossCmd = 0, ovrCmd = 0, sonetCmd = 0, clrCnt = 0, strapCmd = 0;
  logic [7:0] regRdata;
  logic regRdValid, inputFailSeen, secondaryInputsFailed, inactivityAlarm;
  logic mainStdOverride, mainStdSonet, standardStrapPin, firstTimingOutput;
  logic firstOutputOn, compositeTimingOutput, secondOutputOn;
  logic dpllClockRun, dpllEnable, phaseMeasureMode;
  int firstEdges, compHigh, bad_count = 0, cmp_count = 0, cyc = 0;
  logic [7:0] ra [7] = '{8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h64, 8'h63, 8'h65};
  logic [7:0] rv [7] = '{8'h06, 8'h04, 8'h08, 8'h01, 8'h01, 8'hf6, 8'h01};
  amb_activity_bits_cfg #(.CYCLE_TICKS(8)) amb_activity_bits_cfg_i (.core_clk, .sys_rst,
    .regReq, .regRdata, .regRdValid, .inputFailSeen, .secondaryInputsFailed,
    .inactivityAlarm, .mainStdOverride, .mainStdSonet, .standardStrapPin,
    .firstTimingOutput, .firstOutputOn, .compositeTimingOutput, .secondOutputOn,
    .dpllClockRun, .dpllEnable, .phaseMeasureMode);
  amb_far_end amb_far_end_i (.core_clk, .failCmd, .lossCmd, .ovrCmd, .sonetCmd, .clrCnt,
    .strapCmd, .inputFailSeen, .secondaryInputsFailed, .mainStdOverride, .mainStdSonet,
    .standardStrapPin, .firstTimingOutput, .compositeTimingOutput, .firstEdges, .compHigh);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task automatic chkr(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1 regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    #1 regReq = '0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1 regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    #1 regReq = '0;
    chkb(regRdValid, 1'b1);
    chk(regRdata, exp);
  endtask
  task automatic waitAlarm(input logic lvl);
    for (int n = 0; n < 400 && inactivityAlarm !== lvl; n++) idle(1);
    chkb(inactivityAlarm, lvl);
  endtask
  // Window of exactly four composite periods, so the high count shows the duty
  task automatic freq(input logic [7:0] p, input int lo, input int hi, input int cl, input int ch);
    wr(ADDR_PATH, p);
    idle(40);
    clrCnt = 1;
    idle(1);
    clrCnt = 0;
    idle(2500);
    chkr(firstEdges, lo, hi);
    chkr(compHigh, cl, ch);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      test_done;
    end
  end
  initial begin
    idle(12);
    sys_rst = 1'b0;
    idle(6);
    foreach (ra[i]) rdc(ra[i], rv[i]);
    wr(ADDR_LEAK, 8'hff);
    rdc(ADDR_LEAK, 8'h03);
    wr(ADDR_MEAS, 8'hff);
    rdc(ADDR_MEAS, 8'h87);
    chkb(phaseMeasureMode, 1'b1);
    chkb(dpllEnable, 1'b0);
    wr(ADDR_MEAS, 8'h01);
    rdc(8'h70, 8'h00);
    // Walk the two legal clock codes; only code 1 runs the clock
    for (int c = 0; c < 2; c++) begin
      wr(ADDR_PATH, 8'(c));
      idle(2);
      chkb(dpllClockRun, c == 1);
      chkb(dpllEnable, c == 1);
    end
    wr(ADDR_OUT_EN, 8'h20);
    idle(2);
    chkb(firstOutputOn, 1'b1);
    chkb(secondOutputOn, 1'b0);
    wr(ADDR_OUT_EN, 8'h10);
    idle(2);
    chkb(firstOutputOn, 1'b0);
    chkb(secondOutputOn, 1'b1);
    wr(ADDR_OUT_EN, 8'h30);
    rdc(ADDR_OUT_EN, 8'h30);
    lossCmd = 1;
    wr(ADDR_PATH, 8'h01);
    idle(3);
    chkb(firstOutputOn, 1'b1);
    wr(ADDR_PATH, 8'h41);
    idle(2);
    chkb(firstOutputOn, 1'b0);
    chkb(secondOutputOn, 1'b0);
    lossCmd = 0;
    idle(3);
    chkb(secondOutputOn, 1'b1);
    freq(8'h01, 126, 130, 1240, 1260);
    freq(8'h31, 95, 98, 1550, 1575);
    ovrCmd = 1;
    freq(8'h31, 126, 130, 1550, 1575);
    sonetCmd = 1;
    freq(8'h01, 95, 98, 1240, 1260);
    ovrCmd = 0;
    wr(ADDR_UPPER, 8'h03);
    wr(ADDR_LOWER, 8'h01);
    wr(ADDR_CEILING, 8'h05);
    wr(ADDR_LEAK, 8'h00);
    failCmd = 1;
    waitAlarm(1'b1);
    rdc(ADDR_ACC, 8'h03);
    idle(50);
    rdc(ADDR_ACC, 8'h05);
    failCmd = 0;
    waitAlarm(1'b0);
    rdc(ADDR_ACC, 8'h01);
    idle(30);
    rdc(ADDR_ACC, 8'h00);
    // One failed sample adds exactly one to the bucket and leaks back out, at each of the four leak codes
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_LEAK, 8'(c));
      failCmd = 1;
      idle(1);
      failCmd = 0;
      idle(8 * (1 << c) - 1);
      rdc(ADDR_ACC, 8'h01);
      idle(16);
      rdc(ADDR_ACC, 8'h00);
    end
    // Second reset with the strap high: the standard bit takes the strap level
    strapCmd = 1;
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    idle(6);
    rdc(ADDR_PATH, 8'h11);
    rdc(ADDR_STATUS, 8'h3c);
    test_done;
  end
endmodule
bind amb_activity_bits_cfg amb_sva #(.CYCLE_TICKS(CYCLE_TICKS)) amb_sva_i (.core_clk,
  .sys_rst, .regReq, .regRdValid, .secondaryInputsFailed, .firstTimingOutput,
  .firstOutputOn, .compositeTimingOutput, .secondOutputOn, .dpllClockRun, .dpllEnable,
  .phaseMeasureMode);
